/* File: hdl/dgt_pkg.sv */
// Constants for the dual general timer unit: register indices, field positions,
// reset values and timing figures.
// Assumes a 16-bit register port addressed by word index.
`default_nettype none
package dgt_pkg;
  // ************************************************************
  // Register bus geometry.
  // ************************************************************
  localparam int ADDR_W = 5;   // Register index width.
  localparam int DATA_W = 16;  // Register data width.
  // ************************************************************
  // Register indices.
  // ************************************************************
  localparam logic [4:0] IDX_TIMER_CONTROL_ZERO = 5'h00;  // Clock selects, enables, clear-on-match.
  localparam logic [4:0] IDX_UNIT_MODE_ZERO = 5'h01;      // Capture selects and output modes.
  localparam logic [4:0] IDX_UNIT_MODE_ONE = 5'h02;       // One-shot select.
  localparam logic [4:0] IDX_OUTPUT_CONTROL_TWO = 5'h03;  // Timer one output mode.
  localparam logic [4:0] IDX_EXT_IRQ_EDGE_CONFIG = 5'h04; // Capture edge selects.
  localparam logic [4:0] IDX_NOISE_TIME = 5'h05;          // Filter elimination time in samples.
  localparam logic [4:0] IDX_OVERFLOW_STATUS = 5'h06;     // Overflow flags, write one to clear.
  localparam logic [4:0] IDX_TZ_COUNT = 5'h07;            // Timer zero count, read only.
  localparam logic [4:0] IDX_TO_COUNT = 5'h08;            // Timer one count, read only.
  localparam logic [4:0] IDX_TZ_CMP_BASE = 5'h09;         // Seven timer zero compares at 09h..0fh.
  localparam logic [4:0] IDX_TO_CMP_BASE = 5'h10;         // Two timer one compares at 10h..11h.
  // ************************************************************
  // Field positions in the control, mode and status registers, and select codes.
  // ************************************************************
  localparam int TZ_CS_LSB = 0;  // Timer zero clock select, two bits.
  localparam int TZ_CE_BIT = 2;  // Timer zero count enable.
  localparam int TZ_COM_BIT = 3; // Timer zero clear on match.
  localparam int TO_CS_LSB = 4;  // Timer one clock select, two bits.
  localparam int TO_CE_BIT = 6;  // Timer one count enable.
  localparam int TO_COM_BIT = 7; // Timer one clear on match.
  // Unit mode zero: bits 0..2 capture select a..c, bits 3..5 output modes a,c,e.
  localparam int CAP_LSB = 0;
  localparam int OMODE_LSB = 3;
  localparam int OST_BIT = 0;    // One-shot select in unit mode one.
  localparam int TOA_MODE_BIT = 0; // Timer one output a mode in output control two.
  localparam int OVF_TZ_BIT = 0; // Timer zero overflow flag.
  localparam int OVF_TO_BIT = 1; // Timer one overflow flag.
  // Edge select codes, two bits per capture input.
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Clock select code for the external count pin.
  localparam logic [1:0] CS_EXT = 2'h3;
  // ************************************************************
  // Reset values and timing.
  // ************************************************************
  localparam logic [15:0] REG_RESET = 16'h0000; // Every register clears on reset.
  localparam logic [15:0] COUNT_MAX = 16'hffff; // Last count before overflow.
  localparam int NOISE_SAMPLE_DIV = 2;          // Filter samples every two system clocks.
  localparam int NOISE_W = 4;                   // Width of the elimination time field.
endpackage
`default_nettype wire

/* File: hdl/dgt_timer_unit.sv */
// Dual general timer unit: timer zero with seven compares, three capture
// registers and six outputs, timer one with two compares and two outputs.
// Assumes pins arrive asynchronously and a single-cycle register port master.
//
// How it works
// R1 - Timer zero: 16-bit interval, free-run, event counter.
// R2 - Timer zero clock: sysclk/2,/4,/8 or pin.
// R3 - Timer zero overflow pulses irq, sets flag.
// R4 - Interval match pulses irq, clears next count.
// R5 - External clear input clears timer zero always.
// R6 - Enable starts; repeat ignored; clear stops, zeroes.
// R7 - Clear-on-match bit: 0 free-run, 1 interval.
// R8 - Seven compares irq; shared ones compare or capture.
// R9 - Compare match drives output logic and irq.
// R10 - Outputs a,c,e toggle or set/reset; others toggle.
// R11 - Free-run overflow wraps count to zero.
// R12 - First interval n, later n+1 clocks.
// R13 - Capture inputs latch count, hold until next.
// R14 - Capture edge: rising, falling or both.
// R15 - One-shot bit in free-run gives one-shot.
// R16 - One-shot overflow: irq, stop, zero, enable kept.
// R17 - Rewrite enable or clear restarts one-shot standby.
// R18 - Timer one clock: sysclk/4,/8,/16 or pin.
// R19 - Timer one overflow sets flag, no irq.
// R20 - Timer one interval, second compare, free-run wrap.
// R21 - Timer one output a toggle or set/reset.
// R22 - Timer one enable, clear and reset behaviour.
// R23 - Count/clear pins filtered, sampled every two clocks.
// R24 - Toggle on own match; set/reset from pair.
// R25 - Period compare clears; clear acts next clock.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none
module dgt_timer_unit (
  input wire logic clk_sys_i,                    // System clock, 200 MHz.
  input wire logic arst_n_i,                     // Asynchronous reset, active low.
  input wire logic [dgt_pkg::ADDR_W-1:0] addr_i, // Register index.
  input wire logic [dgt_pkg::DATA_W-1:0] wdata_i, // Write data.
  input wire logic wr_i,                         // Write strobe.
  input wire logic rd_i,                         // Read strobe.
  output logic [dgt_pkg::DATA_W-1:0] rdata_o,    // Read data, one cycle after the strobe.
  input wire logic tz_external_count_in_i,       // Timer zero external count pin.
  input wire logic tz_external_clear_in_i,       // Timer zero external clear pin.
  input wire logic to_external_count_in_i,       // Timer one external count pin.
  input wire logic to_external_clear_in_i,       // Timer one external clear pin.
  input wire logic ext_irq_in_a_i,               // Capture trigger for shared register a.
  input wire logic ext_irq_in_b_i,               // Capture trigger for shared register b.
  input wire logic ext_irq_in_c_i,               // Capture trigger for shared register c.
  output logic tz_overflow_irq_o,                // Timer zero overflow pulse.
  output logic [6:0] tz_match_irq_o,             // Timer zero compare match pulses.
  output logic to_period_match_irq_o,            // Timer one period match pulse.
  output logic to_second_match_irq_o,            // Timer one second compare match pulse.
  output logic [5:0] tz_output_o,                // Timer zero output pins a..f.
  output logic [1:0] to_output_o                 // Timer one output pins a..b.
);
  // ************************************************************
  // Software registers.
  // ************************************************************
  logic [7:0] timer_control_zero; // Clock selects, enables and clear-on-match bits.
  logic [5:0] unit_mode_zero;     // Capture selects and output modes.
  logic one_shot_select;          // One-shot request for timer zero.
  logic to_output_a_mode;         // Timer one output a mode.
  logic [5:0] ext_irq_edge_config; // Edge select per capture input.
  logic [dgt_pkg::NOISE_W-1:0] noise_time; // Filter elimination time in samples.
  logic tz_overflow_flag;         // Sticky timer zero overflow.
  logic to_overflow_flag;         // Sticky timer one overflow.
  logic [15:0] tz_cmp [7];        // Timer zero compares; 4..6 are the shared ones.
  logic [15:0] to_cmp [2];        // Timer one compares.
  logic [15:0] timer_zero;        // Timer zero count.
  logic [15:0] timer_one;         // Timer one count.
  logic tz_run;                   // Timer zero is counting.
  logic to_run;                   // Timer one is counting.

  // Address decode for writes.
  wire wr_ctrl = wr_i && (addr_i == dgt_pkg::IDX_TIMER_CONTROL_ZERO);
  wire wr_um0 = wr_i && (addr_i == dgt_pkg::IDX_UNIT_MODE_ZERO);
  wire wr_um1 = wr_i && (addr_i == dgt_pkg::IDX_UNIT_MODE_ONE);
  wire wr_oc2 = wr_i && (addr_i == dgt_pkg::IDX_OUTPUT_CONTROL_TWO);
  wire wr_edge = wr_i && (addr_i == dgt_pkg::IDX_EXT_IRQ_EDGE_CONFIG);
  wire wr_noise = wr_i && (addr_i == dgt_pkg::IDX_NOISE_TIME);
  wire wr_ovf = wr_i && (addr_i == dgt_pkg::IDX_OVERFLOW_STATUS);

  // Decoded control fields.
  wire [1:0] tz_cs = timer_control_zero[dgt_pkg::TZ_CS_LSB +: 2];
  wire [1:0] to_cs = timer_control_zero[dgt_pkg::TO_CS_LSB +: 2];
  wire tz_count_enable = timer_control_zero[dgt_pkg::TZ_CE_BIT];
  wire to_count_enable = timer_control_zero[dgt_pkg::TO_CE_BIT];
  wire tz_clear_on_match = timer_control_zero[dgt_pkg::TZ_COM_BIT];
  wire to_clear_on_match = timer_control_zero[dgt_pkg::TO_COM_BIT];
  wire [2:0] cap_sel = unit_mode_zero[dgt_pkg::CAP_LSB +: 3];
  wire tz_one_shot = one_shot_select && !tz_clear_on_match; // Only meaningful in free-run. [R15]

  // ************************************************************
  // Pin synchronisers and noise filters.
  // ************************************************************
  wire [6:0] pin_raw = {ext_irq_in_c_i, ext_irq_in_b_i, ext_irq_in_a_i, to_external_clear_in_i,
                        to_external_count_in_i, tz_external_clear_in_i, tz_external_count_in_i};
  logic [6:0] pin_meta; // First stage, read only by the second stage.
  logic [6:0] pin_sync; // Second stage, safe to use.
  logic [6:0] pin_prev; // Previous level for edge detection.
  logic sample_en;      // Filter sample strobe, every two clocks.
  logic [3:0] flt_lvl;  // Filtered count and clear levels.
  logic [3:0] flt_prev; // Previous filtered levels.

  // Two-flop synchroniser for every pin, and the sample strobe.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
      pin_prev <= 7'h00;
      sample_en <= 1'b0;
      flt_prev <= 4'h0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      sample_en <= !sample_en; // Toggling gives one strobe per two clocks. [R23]
      flt_prev <= flt_lvl;
    end
  end

  // One filter per count or clear pin: a level passes once held for the programmed samples.
  for (genvar f = 0; f < 4; f++) begin : g_filter
    logic [dgt_pkg::NOISE_W-1:0] run_len; // Samples the new level has held.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        run_len <= '0;
        flt_lvl[f] <= 1'b0;
      end else if (sample_en) begin
        if (pin_sync[f] == flt_lvl[f]) begin
          run_len <= '0; // Short glitch ended, start again. [R23]
        end else if (run_len >= noise_time) begin
          flt_lvl[f] <= pin_sync[f];
          run_len <= '0;
        end else begin
          run_len <= run_len + 1'b1;
        end
      end
    end
  end

  wire tz_ext_tick = flt_lvl[0] && !flt_prev[0]; // Counted edge of the timer zero pin.
  wire tz_ext_clr = flt_lvl[1] && !flt_prev[1];  // Clear edge, acts next clock. [R25]
  wire to_ext_tick = flt_lvl[2] && !flt_prev[2];
  wire to_ext_clr = flt_lvl[3] && !flt_prev[3];

  // Capture trigger per shared register according to its edge select.
  logic [2:0] cap_trig;
  for (genvar c = 0; c < 3; c++) begin : g_edge
    wire rise = pin_sync[4+c] && !pin_prev[4+c];
    wire fall = !pin_sync[4+c] && pin_prev[4+c];
    wire [1:0] sel = ext_irq_edge_config[2*c +: 2];
    assign cap_trig[c] = ((sel == dgt_pkg::EDGE_RISE) && rise) || ((sel == dgt_pkg::EDGE_FALL) && fall) ||
                         ((sel == dgt_pkg::EDGE_BOTH) && (rise || fall)); // [R14]
  end

  // ************************************************************
  // Prescaler and count clock selection.
  // ************************************************************
  logic [3:0] prescale; // Free-running divider of the system clock.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end
  wire div2 = prescale[0];
  wire div4 = &prescale[1:0];
  wire div8 = &prescale[2:0];
  wire div16 = &prescale;
  wire tz_tick = (tz_cs == 2'h0) ? div2 : (tz_cs == 2'h1) ? div4 :
                 (tz_cs == 2'h2) ? div8 : tz_ext_tick; // [R2]
  wire to_tick = (to_cs == 2'h0) ? div4 : (to_cs == 2'h1) ? div8 :
                 (to_cs == 2'h2) ? div16 : to_ext_tick; // [R18]

  // ************************************************************
  // Timer zero counter.
  // ************************************************************
  wire tz_start = wr_ctrl && wdata_i[dgt_pkg::TZ_CE_BIT];
  wire tz_stop = wr_ctrl && !wdata_i[dgt_pkg::TZ_CE_BIT];
  wire tz_adv = tz_run && tz_tick && !tz_stop && !tz_ext_clr;
  wire tz_period_hit = tz_clear_on_match && (timer_zero == tz_cmp[2]); // Period compare clears. [R25]
  wire tz_ovf = tz_adv && !tz_period_hit && (timer_zero == dgt_pkg::COUNT_MAX);
  logic tz_upd; // Count advanced, cleared by the clear pin or started last cycle, so compares are fresh.

  // Counting, stopping, clearing and one-shot standby.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_zero <= 16'h0000; // Reset clears and stops. [R6]
      tz_run <= 1'b0;
    end else if (tz_stop) begin
      timer_zero <= 16'h0000; // Disable clears and stops. [R6]
      tz_run <= 1'b0;
    end else if (tz_ext_clr) begin
      timer_zero <= 16'h0000; // Clear in every mode. [R5]
      tz_run <= tz_count_enable || tz_start; // Also restarts one-shot standby; a start beside it is kept. [R17]
    end else if (tz_start && !tz_run) begin
      tz_run <= 1'b1; // Start or restart; a repeated set while running is ignored. [R6] [R17]
    end else if (tz_adv) begin
      if (tz_period_hit) begin
        timer_zero <= 16'h0000; // Cleared on the count clock after the match. [R4] [R12]
      end else if (tz_ovf) begin
        timer_zero <= 16'h0000; // Wrap to zero. [R11] [R16]
        tz_run <= !tz_one_shot; // One-shot stops, enable stays set. [R16]
      end else begin
        timer_zero <= timer_zero + 16'h0001; // [R1]
      end
    end
  end

  // ************************************************************
  // Timer one counter.
  // ************************************************************
  wire to_start = wr_ctrl && wdata_i[dgt_pkg::TO_CE_BIT];
  wire to_stop = wr_ctrl && !wdata_i[dgt_pkg::TO_CE_BIT];
  wire to_adv = to_run && to_tick && !to_stop && !to_ext_clr;
  wire to_period_hit = to_clear_on_match && (timer_one == to_cmp[0]);
  wire to_ovf = to_adv && !to_period_hit && (timer_one == dgt_pkg::COUNT_MAX);
  logic to_upd; // Count advanced, cleared by the clear pin or started last cycle.

  // Counting, stopping and clearing of timer one.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_one <= 16'h0000; // [R22]
      to_run <= 1'b0;
    end else if (to_stop) begin
      timer_one <= 16'h0000; // [R22]
      to_run <= 1'b0;
    end else if (to_ext_clr) begin
      timer_one <= 16'h0000; // Clear in any mode. [R22]
      to_run <= to_run || to_start; // A start in the same cycle is not lost.
    end else if (to_start && !to_run) begin
      to_run <= 1'b1; // Start; a repeated set falls through and keeps counting. [R22]
    end else if (to_adv) begin
      if (to_period_hit || to_ovf) begin
        timer_one <= 16'h0000; // Interval clear or free-run wrap. [R20]
      end else begin
        timer_one <= timer_one + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Compare matches, events and outputs.
  // ************************************************************
  logic [6:0] tz_match; // Live match per timer zero compare.
  for (genvar m = 0; m < 7; m++) begin : g_tz_match
    wire is_cap = (m >= 4) && cap_sel[(m >= 4) ? m - 4 : 0]; // Capturing registers never match. [R8]
    assign tz_match[m] = tz_upd && !is_cap && (timer_zero == tz_cmp[m]);
  end
  wire [1:0] to_match = {to_upd && (timer_one == to_cmp[1]), to_upd && (timer_one == to_cmp[0])};

  // Event pulses out of the block and the freshness flags.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tz_upd <= 1'b0;
      to_upd <= 1'b0;
      tz_match_irq_o <= 7'h00;
      tz_overflow_irq_o <= 1'b0;
      to_period_match_irq_o <= 1'b0;
      to_second_match_irq_o <= 1'b0;
    end else begin
      tz_upd <= tz_adv || tz_ext_clr || (tz_start && !tz_run);
      to_upd <= to_adv || to_ext_clr || (to_start && !to_run);
      tz_match_irq_o <= tz_match; // One pulse per match. [R8] [R9] [R4]
      tz_overflow_irq_o <= tz_ovf; // [R3] [R16]
      to_period_match_irq_o <= to_match[0]; // [R20]
      to_second_match_irq_o <= to_match[1]; // [R20]
    end
  end

  // Timer zero outputs: even outputs may use set/reset with the next compare as reset. [R10]
  for (genvar o = 0; o < 6; o++) begin : g_tz_out
    wire sr_mode = ((o % 2) == 0) && unit_mode_zero[dgt_pkg::OMODE_LSB + o / 2];
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tz_output_o[o] <= 1'b0;
      end else if (sr_mode) begin
        if (tz_match[o]) begin
          tz_output_o[o] <= 1'b1; // Set on own match. [R24]
        end else if (tz_match[(o < 5) ? o + 1 : o]) begin
          tz_output_o[o] <= 1'b0; // Reset on paired match. [R24]
        end
      end else if (tz_match[o]) begin
        tz_output_o[o] <= !tz_output_o[o]; // Toggle. [R9] [R24]
      end
    end
  end

  // Timer one outputs: a has toggle or set/reset, b toggles only.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      to_output_o <= 2'h0;
    end else begin
      if (to_output_a_mode) begin
        if (to_match[0]) begin
          to_output_o[0] <= 1'b1; // [R21] [R24]
        end else if (to_match[1]) begin
          to_output_o[0] <= 1'b0; // [R21] [R24]
        end
      end else if (to_match[0]) begin
        to_output_o[0] <= !to_output_o[0]; // [R21]
      end
      if (to_match[1]) begin
        to_output_o[1] <= !to_output_o[1]; // [R21]
      end
    end
  end

  // ************************************************************
  // Register writes, captures and flags.
  // ************************************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_control_zero <= 8'h00;
      unit_mode_zero <= 6'h00;
      one_shot_select <= 1'b0;
      to_output_a_mode <= 1'b0;
      ext_irq_edge_config <= 6'h00;
      noise_time <= '0;
      tz_overflow_flag <= 1'b0;
      to_overflow_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_control_zero <= wdata_i[7:0]; // [R7]
      end
      if (wr_um0) begin
        unit_mode_zero <= wdata_i[5:0];
      end
      if (wr_um1) begin
        one_shot_select <= wdata_i[dgt_pkg::OST_BIT];
      end
      if (wr_oc2) begin
        to_output_a_mode <= wdata_i[dgt_pkg::TOA_MODE_BIT];
      end
      if (wr_edge) begin
        ext_irq_edge_config <= wdata_i[5:0];
      end
      if (wr_noise) begin
        noise_time <= wdata_i[dgt_pkg::NOISE_W-1:0];
      end
      // A new overflow wins over a clear in the same cycle.
      tz_overflow_flag <= tz_ovf || (tz_overflow_flag && !(wr_ovf && wdata_i[dgt_pkg::OVF_TZ_BIT])); // [R3]
      to_overflow_flag <= to_ovf || (to_overflow_flag && !(wr_ovf && wdata_i[dgt_pkg::OVF_TO_BIT])); // [R19]
    end
  end

  // Compare storage; shared registers latch the count on their trigger when capturing.
  for (genvar r = 0; r < 7; r++) begin : g_tz_cmp
    wire wr_me = wr_i && (addr_i == dgt_pkg::IDX_TZ_CMP_BASE + 5'(r));
    wire cap_me = (r >= 4) && cap_sel[(r >= 4) ? r - 4 : 0] && cap_trig[(r >= 4) ? r - 4 : 0];
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tz_cmp[r] <= dgt_pkg::REG_RESET;
      end else if (cap_me) begin
        tz_cmp[r] <= timer_zero; // Held until the next trigger. [R13]
      end else if (wr_me) begin
        tz_cmp[r] <= wdata_i;
      end
    end
  end
  for (genvar t = 0; t < 2; t++) begin : g_to_cmp
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        to_cmp[t] <= dgt_pkg::REG_RESET;
      end else if (wr_i && (addr_i == dgt_pkg::IDX_TO_CMP_BASE + 5'(t))) begin
        to_cmp[t] <= wdata_i;
      end
    end
  end

  // ************************************************************
  // Read path: data stand only in the cycle after the strobe.
  // ************************************************************
  wire [4:0] tz_idx = addr_i - dgt_pkg::IDX_TZ_CMP_BASE;
  wire [4:0] to_idx = addr_i - dgt_pkg::IDX_TO_CMP_BASE;
  wire [15:0] rd_mux =
    (addr_i == dgt_pkg::IDX_TIMER_CONTROL_ZERO) ? {8'h00, timer_control_zero} :
    (addr_i == dgt_pkg::IDX_UNIT_MODE_ZERO) ? {10'h000, unit_mode_zero} :
    (addr_i == dgt_pkg::IDX_UNIT_MODE_ONE) ? {15'h0000, one_shot_select} :
    (addr_i == dgt_pkg::IDX_OUTPUT_CONTROL_TWO) ? {15'h0000, to_output_a_mode} :
    (addr_i == dgt_pkg::IDX_EXT_IRQ_EDGE_CONFIG) ? {10'h000, ext_irq_edge_config} :
    (addr_i == dgt_pkg::IDX_NOISE_TIME) ? 16'(noise_time) :
    (addr_i == dgt_pkg::IDX_OVERFLOW_STATUS) ? {14'h0000, to_overflow_flag, tz_overflow_flag} :
    (addr_i == dgt_pkg::IDX_TZ_COUNT) ? timer_zero :
    (addr_i == dgt_pkg::IDX_TO_COUNT) ? timer_one :
    (tz_idx < 5'h07) ? tz_cmp[tz_idx[2:0]] :
    (to_idx < 5'h02) ? to_cmp[to_idx[0]] : 16'h0000; // Unmapped reads return zero.

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: tb/dgt_pin_model.sv */
// Pin model for the external count inputs of the timer unit.
// Assumes one system clock; the pin rests low while disabled.
`default_nettype none
module dgt_pin_model (
  input wire logic clk_i, // System clock.
  input wire logic en_i, // Pulse train enable.
  output logic pin_o // Count pin, eight clocks low then eight high.
);
  logic [3:0] cnt = 4'h0; // Phase counter.
  // Pulses stay far above the filter's elimination time, so none is lost.
  always_ff @(posedge clk_i) begin
    cnt <= en_i ? cnt + 4'h1 : 4'h0;
  end
  assign pin_o = cnt[3];
endmodule
`default_nettype wire

/* File: tb/dgt_timer_unit_asserts.sv */
// Checker for the timer unit's read data, pulses and output pins.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module dgt_timer_unit_asserts (
  input wire logic clk_sys_i, // Clock.
  input wire logic arst_n_i, // Reset, active low.
  input wire logic rd_i, // Read strobe.
  input wire logic [dgt_pkg::DATA_W-1:0] rdata_o, // Read data.
  input wire logic tz_overflow_irq_o, // Overflow pulse.
  input wire logic [6:0] tz_match_irq_o, // Match pulses.
  input wire logic to_period_match_irq_o, // Period pulse.
  input wire logic to_second_match_irq_o, // Second pulse.
  input wire logic [5:0] tz_output_o, // Timer zero pins.
  input wire logic [1:0] to_output_o // Timer one pins.
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // A pulse that is high for one cycle and then drops.
  sequence s_one_cycle(x);
    x ##1 !x;
  endsequence
  a_read_data_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside slot");
  a_ovf_pulse_once: assert property (tz_overflow_irq_o |-> s_one_cycle(tz_overflow_irq_o)) else $error("long pulse");
  a_to_period_once: assert property (to_period_match_irq_o |-> s_one_cycle(to_period_match_irq_o)) else $error("long");
  a_out_b_toggle: assert property ($changed(tz_output_o[1]) |-> tz_match_irq_o[1]) else $error("pin b moved");
  a_out_d_toggle: assert property ($changed(tz_output_o[3]) |-> tz_match_irq_o[3]) else $error("pin d moved");
  a_out_f_toggle: assert property ($changed(tz_output_o[5]) |-> tz_match_irq_o[5]) else $error("pin f moved");
  a_out_c_cause: assert property ($changed(tz_output_o[2]) |-> |tz_match_irq_o[3:2]) else $error("pin c moved");
  a_to_out_b: assert property ($changed(to_output_o[1]) |-> to_second_match_irq_o) else $error("one b moved");
endmodule
`default_nettype wire

/* File: tb/dual_general_timer_unit_tb.sv */
// Self-checking bench for the dual general timer unit.
// Assumes the pin model and the checker are compiled before it.
`default_nettype none
module dual_general_timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic t; logic [1:0] cs; logic [15:0] n; int gap;} dgt_row_t;
  dgt_row_t rows[5] = '{'{0, 0, 3, 8}, '{0, 1, 3, 16}, '{0, 2, 0, 8}, '{1, 0, 1, 8}, '{1, 2, 0, 16}};
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, pin_en = 1'b0, pin, tz_clr = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [6:0] tz_irq;
  logic to_pm, to_sm;
  int fails = 0, check_count = 0, n;
  always #2.5 clk_sys_i = ~clk_sys_i;
  dgt_pin_model pm_u (.clk_i(clk_sys_i), .en_i(pin_en), .pin_o(pin));
  dgt_timer_unit dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .tz_external_count_in_i(pin), .tz_external_clear_in_i(tz_clr),
    .to_external_count_in_i(pin), .to_external_clear_in_i(1'b0), .ext_irq_in_a_i(pin), .ext_irq_in_b_i(1'b0),
    .ext_irq_in_c_i(1'b0), .tz_overflow_irq_o(), .tz_match_irq_o(tz_irq), .to_period_match_irq_o(to_pm),
    .to_second_match_irq_o(to_sm), .tz_output_o(), .to_output_o());
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys_i) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk_sys_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys_i) {rd, addr} <= {1'b1, a};
    @(posedge clk_sys_i) rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Counts cycles up to the next period pulse of the chosen timer.
  task automatic gap(input logic t, output int c);
    @(posedge clk_sys_i) #1;
    for (c = 1; c < 300 && (t ? to_pm : tz_irq[2]) !== 1'b1; c++) @(posedge clk_sys_i) #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_reg(dgt_pkg::IDX_TIMER_CONTROL_ZERO, d);
    check(d, 0);
    rd_reg(5'h1f, d);
    check(d, 0);
    $display("reset test done");
    // Interval rows: the steady gap is (n + 1) count clocks.
    foreach (rows[i]) begin
      wr_reg(rows[i].t ? dgt_pkg::IDX_TO_CMP_BASE : dgt_pkg::IDX_TZ_CMP_BASE + 5'h02, rows[i].n);
      wr_reg(dgt_pkg::IDX_TIMER_CONTROL_ZERO, rows[i].t ? {8'h00, 2'b11, rows[i].cs, 4'h0} : {12'h000, 2'b11, rows[i].cs});
      repeat (3) gap(rows[i].t, n);
      check(n, rows[i].gap);
      wr_reg(dgt_pkg::IDX_TIMER_CONTROL_ZERO, 16'h0000);
      rd_reg(rows[i].t ? dgt_pkg::IDX_TO_COUNT : dgt_pkg::IDX_TZ_COUNT, d);
      check(d, 0);
      $display("row %0d done", i);
    end
    // Event counting: five pin pulses arrive before the read; shared register a captures on rising pin edges.
    wr_reg(dgt_pkg::IDX_UNIT_MODE_ZERO, 16'h0001);
    wr_reg(dgt_pkg::IDX_EXT_IRQ_EDGE_CONFIG, 16'h0001);
    wr_reg(dgt_pkg::IDX_TIMER_CONTROL_ZERO, 16'h0007);
    pin_en <= 1'b1;
    repeat (86) @(posedge clk_sys_i);
    rd_reg(dgt_pkg::IDX_TZ_COUNT, d);
    check(d, 5);
    $display("event test done");
    // The last pulse is captured before it counts, then the clear pin zeroes the count.
    @(posedge clk_sys_i) {pin_en, tz_clr} <= 2'b01;
    repeat (12) @(posedge clk_sys_i);
    rd_reg(dgt_pkg::IDX_TZ_COUNT, d);
    check(d, 0);
    rd_reg(dgt_pkg::IDX_TZ_CMP_BASE + 5'h04, d);
    check(d, 5);
    $display("clear and capture test done");
    print_verdict;
  end
  initial begin
    #50us;
    fails++;
    print_verdict;
  end
endmodule
bind dgt_timer_unit dgt_timer_unit_asserts chk_u (.*);
`default_nettype wire
